// file: bench/mic_far_end.sv
// Far-side model: switch contacts, index channel and motion-core event lines
`timescale 1ns/1ns
`default_nettype none

module mic_far_end
  import mic_pkg::*;
(
  output var mic_switch_s switch_pins,
  output var mic_event_s core_events
);
  // ************************************************
  // Idle levels
  // ************************************************
  // Contacts open (low-active pins high), index low, no events
  initial begin
    switch_pins = mic_switch_s'(EXT_ACTIVE_LOW);
    core_events = '0;
  end

  // ************************************************
  // Commands, issued just after a clock edge
  // ************************************************
  // One contact change; either direction is an event
  task automatic toggle_pin(input int i);
    switch_pins[i] <= ~switch_pins[i];
  endtask

  // Core lines are levels, held as long as the bench wants
  task automatic set_event(input int i, input logic v);
    core_events[i] <= v;
  endtask
endmodule

`default_nettype wire

// file: bench/mic_irq_ctrl_bench.sv
// Self-checking bench of the motion interrupt controller
`timescale 1ns/1ns
`default_nettype none

module mic_irq_ctrl_bench;
  import mic_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  mic_switch_s switch_pins;
  mic_event_s core_events;
  logic irq_out;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int n_compared = 0;

  // 100 ns clock
  always #50 pclk = ~pclk;

  mic_irq_ctrl mic_irq_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_pins(switch_pins), .core_events(core_events), .irq_out(irq_out));

  mic_far_end mic_far_end_i (.switch_pins(switch_pins), .core_events(core_events));

  // ************************************************
  // Tasks
  // ************************************************
  task automatic print_verdict();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the idle cycle after it keeps psel from toggling twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (n == 20) begin
      miscompares++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ************************************************
  // Sequence
  // ************************************************
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wt(4);
    chk({31'h0, irq_out}, 32'h0);
    rd_chk(ADDR_POLARITY, 32'h0);
    rd_chk(ADDR_ENABLE, 32'h0);
    rd_chk(ADDR_STATUS, 32'h0);
    // Unmapped word answers with an error and zero data
    apb(1'b0, 12'h344, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Input polarity moves the sensed level but fakes no event
    rd_chk(ADDR_SENSE, 32'h0);
    // Sensed level is read-only: a write is ignored without an error
    apb(1'b1, ADDR_SENSE, 32'h1f);
    chk({31'h0, err}, 32'h0);
    rd_chk(ADDR_SENSE, 32'h0);
    apb(1'b1, ADDR_POLARITY, 32'h1f);
    rd_chk(ADDR_SENSE, 32'h1f);
    rd_chk(ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_POLARITY, 32'h0);
    apb(1'b1, ADDR_ENABLE, 32'hffffffff);
    rd_chk(ADDR_ENABLE, 32'h7ff);
    apb(1'b1, ADDR_ENABLE, 32'h0);
    // Every pin, both directions, one event each
    for (int i = 0; i < NUM_EXT; i++) begin
      for (int k = 0; k < 2; k++) begin
        mic_far_end_i.toggle_pin(i);
        wt(8);
        rd_chk(ADDR_STATUS, 32'h1 << i);
      end
    end
    // Core lines held high across a read: one event only
    for (int i = 0; i < NUM_INT; i++) begin
      mic_far_end_i.set_event(i, 1'b1);
      wt(3);
      rd_chk(ADDR_STATUS, 32'h20 << i);
      rd_chk(ADDR_STATUS, 32'h0);
      mic_far_end_i.set_event(i, 1'b0);
      wt(1);
    end
    // Output follows enabled pending flags and the level select
    apb(1'b1, ADDR_ENABLE, 32'h200);
    mic_far_end_i.set_event(SRC_WRAP - NUM_EXT, 1'b1);
    wt(3);
    chk({31'h0, irq_out}, 32'h0);
    mic_far_end_i.set_event(SRC_TIMEOUT - NUM_EXT, 1'b1);
    wt(3);
    chk({31'h0, irq_out}, 32'h1);
    apb(1'b1, ADDR_POLARITY, 32'h20);
    wt(2);
    chk({31'h0, irq_out}, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h0);
    wt(2);
    chk({31'h0, irq_out}, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h200);
    wt(2);
    chk({31'h0, irq_out}, 32'h1);
    apb(1'b1, ADDR_ENABLE, 32'h100);
    wt(2);
    chk({31'h0, irq_out}, 32'h0);
    apb(1'b1, ADDR_POLARITY, 32'h0);
    wt(2);
    chk({31'h0, irq_out}, 32'h1);
    print_verdict();
  end
endmodule

`default_nettype wire

// file: common/mic_pkg.sv
// Shared constants, register map and carrier types of the motion interrupt controller
package mic_pkg;

  // ****************************************************************
  // Source counts and bit positions
  // ****************************************************************
  localparam int NUM_SRC = 11;
  localparam int NUM_EXT = 5;
  localparam int NUM_INT = 6;
  localparam int SRC_LEFT_LIMIT = 0;
  localparam int SRC_RIGHT_LIMIT = 1;
  localparam int SRC_LEFT_SLOWDOWN = 2;
  localparam int SRC_RIGHT_SLOWDOWN = 3;
  localparam int SRC_INDEX = 4;
  localparam int SRC_FIFO_EMPTY = 5;
  localparam int SRC_STOP_ACCEPTED = 6;
  localparam int SRC_FIFO_CMD = 7;
  localparam int SRC_WRAP = 8;
  localparam int SRC_TIMEOUT = 9;
  localparam int SRC_DEVIATION = 10;
  localparam int POL_OUT_LEVEL_BIT = 5;
  localparam int POL_W = 6;

  // ****************************************************************
  // Register indices (printed offsets) and byte addresses
  // ****************************************************************
  localparam logic [7:0] IDX_POLARITY = 8'hd0;
  localparam logic [7:0] IDX_ENABLE = 8'hd2;
  localparam logic [7:0] IDX_STATUS = 8'hd4;
  localparam logic [7:0] IDX_SENSE = 8'hd5;
  localparam logic [11:0] ADDR_POLARITY = {2'h0, IDX_POLARITY, 2'h0};
  localparam logic [11:0] ADDR_ENABLE = {2'h0, IDX_ENABLE, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_SENSE = {2'h0, IDX_SENSE, 2'h0};

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [POL_W-1:0] POLARITY_RST = 6'h00;
  localparam logic [NUM_SRC-1:0] ENABLE_RST = 11'h000;
  localparam logic [NUM_SRC-1:0] STATUS_RST = 11'h000;
  // Switch pins are active low, the index channel active high
  localparam logic [NUM_EXT-1:0] EXT_ACTIVE_LOW = 5'h0f;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {REG_NONE, REG_POL, REG_EN, REG_STAT, REG_SENSE} mic_reg_e;

  // Last field is bit 0, so the layout follows the source numbering
  typedef struct packed {
    logic encoder_index_input;
    logic right_slowdown_switch_n;
    logic left_slowdown_switch_n;
    logic right_limit_switch_n;
    logic left_limit_switch_n;
  } mic_switch_s;

  typedef struct packed {
    logic deviation_exceeded;
    logic timeout_reached;
    logic position_counter_wrap;
    logic fifo_cmd_flag_start;
    logic stop_accepted;
    logic fifo_empty;
  } mic_event_s;

endpackage

// file: hdl/mic_irq_ctrl.sv
// Interrupt controller of a single-axis motion controller with an APB register port
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`default_nettype none

module mic_irq_ctrl
  import mic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mic_switch_s switch_pins,
  input wire mic_event_s core_events,
  output logic irq_out
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Full-address match, so misaligned or unknown addresses miss
  function automatic mic_reg_e decode(input logic [11:0] addr);
    mic_reg_e sel;
    sel = REG_NONE;
    case (addr)
      ADDR_POLARITY: sel = REG_POL;
      ADDR_ENABLE: sel = REG_EN;
      ADDR_STATUS: sel = REG_STAT;
      ADDR_SENSE: sel = REG_SENSE;
      default: sel = REG_NONE;
    endcase
    return sel;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [POL_W-1:0] pol_q;
  logic [NUM_SRC-1:0] enable_q;
  logic [NUM_SRC-1:0] status_q;
  logic [NUM_SRC-1:0] status_d;
  logic [NUM_EXT-1:0] sw_meta_q;
  logic [NUM_EXT-1:0] sw_sync_q;
  logic [NUM_EXT-1:0] sw_prev_q;
  logic [2:0] arm_q;
  logic [NUM_INT-1:0] ev_prev_q;
  logic [NUM_EXT-1:0] ext_ev;
  logic [NUM_INT-1:0] int_ev;
  logic [NUM_EXT-1:0] sense_level;
  logic [NUM_SRC-1:0] set_vec;
  logic [NUM_SRC-1:0] clr_vec;
  logic [NUM_SRC-1:0] rd_snap_q;
  logic access;
  logic answer;
  logic commit;
  mic_reg_e sel;

  // ****************************************************************
  // External inputs: synchroniser and edge detect
  // ****************************************************************

  // Two flops before any logic looks at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_q <= '0;
      sw_sync_q <= '0;
    end else begin
      sw_meta_q <= switch_pins;
      sw_sync_q <= sw_meta_q;
    end
  end

  // Previous level for edge compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_prev_q <= '0;
    end else begin
      sw_prev_q <= sw_sync_q;
    end
  end

  // Holds edges off until the pipeline carries real pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q <= 3'h0;
    end else begin
      arm_q <= {arm_q[1:0], 1'b1};
    end
  end

  // Both directions count; a steady pin gives nothing
  assign ext_ev = (sw_sync_q ^ sw_prev_q) & {NUM_EXT{arm_q[2]}};

  // Sensed active level per input; readable, does not change edges
  assign sense_level = sw_sync_q ^ EXT_ACTIVE_LOW ^ pol_q[NUM_EXT-1:0];

  // ****************************************************************
  // Internal events: rising edge of each core signal
  // ****************************************************************

  // Same clock as the core, so no synchroniser is needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_prev_q <= '0;
    end else begin
      ev_prev_q <= core_events;
    end
  end

  // Empty FIFO, stop, flagged command, wrap, timeout, deviation
  assign int_ev = core_events & ~ev_prev_q;
  assign set_vec = {int_ev, ext_ev};

  // ****************************************************************
  // APB slave: one wait state, answer registered
  // ****************************************************************
  assign access = psel & penable;
  assign answer = access & ~pready;
  assign commit = access & pready;
  assign sel = decode(paddr);

  // Ready rises one edge into the access phase, for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= answer;
    end
  end

  // Read data and error captured with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (answer) begin
      pslverr <= (sel == REG_NONE);
      prdata <= '0;
      if (!pwrite) begin
        case (sel)
          REG_POL: prdata <= {26'h0, pol_q};
          REG_EN: prdata <= {21'h0, enable_q};
          REG_STAT: prdata <= {21'h0, status_q};
          REG_SENSE: prdata <= {27'h0, sense_level};
          default: prdata <= '0;
        endcase
      end
    end else if (!access) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
  end

  // Snapshot of reported flags; a read clears only what it showed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_snap_q <= '0;
    end else if (answer) begin
      rd_snap_q <= (!pwrite && sel == REG_STAT) ? status_q : '0;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************

  // Polarity: five input senses plus output level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_q <= POLARITY_RST;
    end else if (commit && pwrite && sel == REG_POL) begin
      pol_q <= pwdata[POL_W-1:0];
    end
  end

  // Enable register, one bit per source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= ENABLE_RST;
    end else if (commit && pwrite && sel == REG_EN) begin
      enable_q <= pwdata[NUM_SRC-1:0];
    end
  end

  // ****************************************************************
  // Pending status
  // ****************************************************************

  // Write-one clear, or clear of the bits a read returned
  always_comb begin
    clr_vec = '0;
    if (commit && sel == REG_STAT) begin
      if (pwrite) begin
        clr_vec = pwdata[NUM_SRC-1:0];
      end else begin
        clr_vec = rd_snap_q;
      end
    end
  end

  // A new event wins over a clear in the same cycle
  assign status_d = (status_q & ~clr_vec) | set_vec;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // ****************************************************************
  // Interrupt output
  // ****************************************************************

  // Flops the output so the pin never glitches on a decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (|(status_q & enable_q)) ^ pol_q[POL_OUT_LEVEL_BIT];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_IRQ_FOLLOWS_PENDING: assert property (
    (|(status_q & enable_q)) && !pol_q[POL_OUT_LEVEL_BIT] |=> irq_out)
    else $error("interrupt not raised for pending enabled flag");

  AST_IRQ_IDLE_LEVEL: assert property (
    !(|(status_q & enable_q)) && !pol_q[POL_OUT_LEVEL_BIT] |=> !irq_out)
    else $error("interrupt active with nothing pending");

  AST_IRQ_ACTIVE_LOW: assert property (
    pol_q[POL_OUT_LEVEL_BIT] |=> irq_out == !$past(|(status_q & enable_q)))
    else $error("inverted interrupt level wrong");

  AST_LIMIT_EDGE: assert property (
    arm_q[2] && $changed(sw_sync_q[SRC_LEFT_LIMIT])
      |=> status_q[SRC_LEFT_LIMIT])
    else $error("left limit toggle not flagged");

  AST_SLOWDOWN_EDGE: assert property (
    ext_ev[SRC_RIGHT_SLOWDOWN] |=> status_q[SRC_RIGHT_SLOWDOWN])
    else $error("right slowdown toggle not flagged");

  AST_INDEX_EDGE: assert property (
    ext_ev[SRC_INDEX] |=> status_q[SRC_INDEX])
    else $error("index toggle not flagged");

  AST_STEADY_NO_EVENT: assert property (
    core_events == $past(core_events) && $stable(sw_sync_q) |-> set_vec == '0)
    else $error("event raised on a steady level");

  AST_FIFO_EMPTY_EDGE: assert property (
    $rose(core_events.fifo_empty) |=> status_q[SRC_FIFO_EMPTY])
    else $error("fifo empty not flagged");

  AST_STOP_EDGE: assert property (
    $rose(core_events.stop_accepted) |=> status_q[SRC_STOP_ACCEPTED])
    else $error("accepted stop not flagged");

  AST_WRAP_EDGE: assert property (
    $rose(core_events.position_counter_wrap) |=> status_q[SRC_WRAP])
    else $error("counter wrap not flagged");

  AST_W1C_KEEPS_ZEROS: assert property (
    commit && pwrite && sel == REG_STAT
      |=> (status_q & ~$past(pwdata[NUM_SRC-1:0])) ==
          (($past(status_q) | $past(set_vec)) & ~$past(pwdata[NUM_SRC-1:0])))
    else $error("status bit changed where zero was written");

  AST_W1C_CLEARS: assert property (
    commit && pwrite && sel == REG_STAT && set_vec == '0
      |=> (status_q & $past(pwdata[NUM_SRC-1:0])) == '0)
    else $error("write of one did not clear status");

  AST_APB_ONE_WAIT: assert property (
    answer |=> pready ##1 !pready)
    else $error("ready not a single cycle after one wait");

  AST_STATUS_READ: assert property (
    answer && !pwrite && sel == REG_STAT
      |=> prdata == {21'h0, $past(status_q)} && !pslverr)
    else $error("status read data wrong");

  AST_CMD_FLAG_EDGE: assert property (
    $rose(core_events.fifo_cmd_flag_start) |=> status_q[SRC_FIFO_CMD])
    else $error("flagged command start not flagged");

  AST_TIMEOUT_EDGE: assert property (
    $rose(core_events.timeout_reached) |=> status_q[SRC_TIMEOUT])
    else $error("timeout not flagged");

  AST_DEVIATION_EDGE: assert property (
    $rose(core_events.deviation_exceeded) |=> status_q[SRC_DEVIATION])
    else $error("deviation not flagged");

  AST_RIGHT_LIMIT_EDGE: assert property (
    arm_q[2] && $changed(sw_sync_q[SRC_RIGHT_LIMIT])
      |=> status_q[SRC_RIGHT_LIMIT])
    else $error("right limit toggle not flagged");

  AST_LEFT_SLOWDOWN_EDGE: assert property (
    arm_q[2] && $changed(sw_sync_q[SRC_LEFT_SLOWDOWN])
      |=> status_q[SRC_LEFT_SLOWDOWN])
    else $error("left slowdown toggle not flagged");

  AST_SET_BEATS_CLEAR: assert property (
    set_vec != '0 |=> (status_q & $past(set_vec)) == $past(set_vec))
    else $error("new event lost to a clear");

  AST_STATUS_STICKY: assert property (
    !(commit && sel == REG_STAT) |=> ($past(status_q) & ~status_q) == '0)
    else $error("status bit dropped without a status access");

  AST_READ_CLEARS: assert property (
    commit && !pwrite && sel == REG_STAT
      |=> (status_q & $past(prdata[NUM_SRC-1:0]) & ~$past(set_vec)) == '0)
    else $error("read did not clear the flags it returned");

  AST_ENABLE_WRITE: assert property (
    commit && pwrite && sel == REG_EN |=> enable_q == $past(pwdata[NUM_SRC-1:0]))
    else $error("enable write not taken");

  AST_POLARITY_WRITE: assert property (
    commit && pwrite && sel == REG_POL |=> pol_q == $past(pwdata[POL_W-1:0]))
    else $error("polarity write not taken");

  AST_SENSE_READ_ONLY: assert property (
    commit && pwrite && sel == REG_SENSE |=> $stable(pol_q) && $stable(enable_q))
    else $error("write to sensed level changed a register");

  AST_UNMAPPED_ERROR: assert property (
    answer && sel == REG_NONE |=> pslverr && prdata == '0)
    else $error("unmapped access without error");

  AST_MAPPED_NO_ERROR: assert property (
    answer && sel != REG_NONE |=> !pslverr)
    else $error("error on a mapped register");

  AST_BUS_QUIET: assert property (
    !access |=> !pready && !pslverr && prdata == '0)
    else $error("bus outputs active outside a transfer");

endmodule

`default_nettype wire
